// [common/mtt_pkg.sv]
package mtt_pkg;
	// ==========================================
	// Register map (byte addresses)
	localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_CLOCK_CONFIG   = 4'h4;
	localparam logic [3:0] ADDR_COUNT          = 4'h8;
	localparam logic [3:0] ADDR_TERMINAL_VALUE = 4'hc;
	localparam logic [3:0] ADDR_POWER_MODE     = 4'h0;

	// ==========================================
	// Field positions
	localparam int SC_OVERFLOW_FLAG  = 7;
	localparam int SC_IRQ_ENABLE     = 6;
	localparam int SC_COUNTER_CLEAR  = 5;
	localparam int SC_COUNTER_HALT   = 4;
	localparam int CFG_CLKSEL_LSB    = 4;
	localparam int CFG_PRESCALE_LSB  = 0;

	// ==========================================
	// Reset values and prescale limit
	localparam logic [7:0] RST_COUNT    = 8'h00;
	localparam logic [7:0] RST_TERMINAL = 8'h00;
	localparam logic [1:0] RST_CLKSEL   = 2'h0;
	localparam logic [3:0] RST_PRESCALE = 4'h0;
	localparam logic [3:0] PRESCALE_MAX = 4'h8;

	// ==========================================
	// Clock source codes
	typedef enum logic [1:0] {
		MTT_SRC_BUS      = 2'b00,
		MTT_SRC_FIXED    = 2'b01,
		MTT_SRC_EXT_FALL = 2'b10,
		MTT_SRC_EXT_RISE = 2'b11
	} mtt_src_t;
endpackage

// [hw/mtt_timer.sv]
`timescale 1ns/100ps
// Functional notes
// - 8-bit up-counter, free-running or limited by a terminal value.
// - Overflow flag sets when count wraps to 00 after terminal value.
// - Flag clears by status read while set, then writing 0 to it.
// - Counter clear write or terminal value write also clears the flag.
// - Interrupt request while irq enable and flag are both 1.
// - Reset sets counter halt and clears interrupt enable.
// - Writing 1 to clear bit zeroes count and flag; reads 0.
// - Halt holds count; clearing halt resumes from held value.
// - Low four status bits read 0.
// - Counting continues in wait mode so overflow can wake.
// - In stop mode the timer is disabled and never wakes.
// - Deep stop wake or stop-by-reset returns timer to reset state.
// - Shallow stop left by interrupt keeps state, count resumes.
// - Debug mode suspends counting; clear or terminal writes still act.
// - External count clock is synchronised to the bus clock.
// - Four sources: bus, fixed clock, pin rising, pin falling.
// - Prescaler divides by 1,2,4,...,256.
// - Upper two source codes select the external pin.
// - Source codes: 00 bus, 01 fixed, 10 fall, 11 rise; reset bus.
// - Prescale codes 0..8 give 1..256; higher give 256; reset 0.
// - Terminal 00 is free-running; write clears count and flag.
// - Count register read-only, reset to 00.
module mtt_timer (
	// Bus clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Count sources
	input  wire logic        fixed_rate_clock,
	input  wire logic        ext_count_clock_in,
	// Power and debug modes
	input  wire logic        stop_mode,
	input  wire logic        deep_stop_wake,
	input  wire logic        debug_active,
	// Interrupt request
	output logic             overflow_irq
);
	// ==========================================
	// Register state
	logic       overflow_flag;
	logic       overflow_irq_enable;
	logic       counter_halt;
	logic [1:0] clock_source_select;
	logic [3:0] prescale_select;
	logic [7:0] terminal_value;
	logic [7:0] count;
	logic       flag_seen;
	logic [7:0] next_count;
	logic       next_flag;

	// ==========================================
	// Bus address phase capture
	logic       ph_valid;
	logic       ph_write;
	logic [3:0] ph_addr;
	logic       addr_ok;

	assign addr_ok = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'b00);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr  <= 4'h0;
		end else if (hready) begin
			ph_valid <= hsel && htrans[1] && addr_ok;
			ph_write <= hwrite;
			ph_addr  <= haddr[3:0];
		end
	end

	logic wr_sc, wr_cfg, wr_tv, rd_sc;
	assign wr_sc  = ph_valid && ph_write && (ph_addr == mtt_pkg::ADDR_STATUS_CONTROL);
	assign wr_cfg = ph_valid && ph_write && (ph_addr == mtt_pkg::ADDR_CLOCK_CONFIG);
	assign wr_tv  = ph_valid && ph_write && (ph_addr == mtt_pkg::ADDR_TERMINAL_VALUE);
	assign rd_sc  = ph_valid && !ph_write && (ph_addr == mtt_pkg::ADDR_STATUS_CONTROL);

	logic clr_req;
	assign clr_req = (wr_sc && hwdata[mtt_pkg::SC_COUNTER_CLEAR]) || wr_tv;

	// Zero-wait slave, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data registered at address phase so it stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite && addr_ok) begin
			case (haddr[3:0])
				mtt_pkg::ADDR_STATUS_CONTROL: hrdata <= {24'h000000, next_flag,
					overflow_irq_enable, 1'b0, counter_halt, 4'h0};
				mtt_pkg::ADDR_CLOCK_CONFIG: hrdata <= {24'h000000, 2'b00,
					clock_source_select, prescale_select};
				mtt_pkg::ADDR_COUNT:          hrdata <= {24'h000000, next_count};
				mtt_pkg::ADDR_TERMINAL_VALUE: hrdata <= {24'h000000, terminal_value};
				default:                      hrdata <= 32'h00000000;
			endcase
		end else begin
			hrdata <= 32'h00000000;
		end
	end

	// ==========================================
	// Deep stop wake acts as a local reset
	logic soft_rst;
	assign soft_rst = deep_stop_wake;

	// Control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overflow_irq_enable <= 1'b0;
			counter_halt        <= 1'b1;
		end else if (soft_rst) begin
			overflow_irq_enable <= 1'b0;
			counter_halt        <= 1'b1;
		end else if (wr_sc) begin
			overflow_irq_enable <= hwdata[mtt_pkg::SC_IRQ_ENABLE];
			counter_halt        <= hwdata[mtt_pkg::SC_COUNTER_HALT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_source_select <= mtt_pkg::RST_CLKSEL;
			prescale_select     <= mtt_pkg::RST_PRESCALE;
		end else if (soft_rst) begin
			clock_source_select <= mtt_pkg::RST_CLKSEL;
			prescale_select     <= mtt_pkg::RST_PRESCALE;
		end else if (wr_cfg) begin
			clock_source_select <= hwdata[mtt_pkg::CFG_CLKSEL_LSB +: 2];
			prescale_select     <= hwdata[mtt_pkg::CFG_PRESCALE_LSB +: 4];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			terminal_value <= mtt_pkg::RST_TERMINAL;
		end else if (soft_rst) begin
			terminal_value <= mtt_pkg::RST_TERMINAL;
		end else if (wr_tv) begin
			terminal_value <= hwdata[7:0];
		end
	end

	// ==========================================
	// External pin synchroniser and edge detect
	logic [2:0] pin_sync;
	logic       ext_level;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_sync <= 3'b000;
		end else begin
			pin_sync <= {pin_sync[1:0], ext_count_clock_in};
		end
	end

	// Level moves only once stages two and three agree; resets to idle low
	// so no false edge follows reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_level <= 1'b0;
		end else if (pin_sync[1] == pin_sync[2]) begin
			ext_level <= pin_sync[2];
		end
	end
	logic ext_rise, ext_fall;
	assign ext_rise = (pin_sync[2:1] == 2'b11) && !ext_level;
	assign ext_fall = (pin_sync[2:1] == 2'b00) && ext_level;

	logic [2:0] fix_sync;
	logic       fix_level;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fix_sync <= 3'b000;
		end else begin
			fix_sync <= {fix_sync[1:0], fixed_rate_clock};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fix_level <= 1'b0;
		end else if (fix_sync[1] == fix_sync[2]) begin
			fix_level <= fix_sync[2];
		end
	end
	logic fix_rise;
	assign fix_rise = (fix_sync[2:1] == 2'b11) && !fix_level;

	// ==========================================
	// Source select and prescaler
	logic run, src_tick;
	// Stop and debug freeze the counter; wait mode does not
	assign run = !counter_halt && !stop_mode && !debug_active;

	always_comb begin
		case (mtt_pkg::mtt_src_t'(clock_source_select))
			mtt_pkg::MTT_SRC_BUS:      src_tick = 1'b1;
			mtt_pkg::MTT_SRC_FIXED:    src_tick = fix_rise;
			mtt_pkg::MTT_SRC_EXT_FALL: src_tick = ext_fall;
			mtt_pkg::MTT_SRC_EXT_RISE: src_tick = ext_rise;
			default:                   src_tick = 1'b1;
		endcase
	end

	function automatic logic [3:0] eff_ps(input logic [3:0] ps);
		eff_ps = (ps > mtt_pkg::PRESCALE_MAX) ? mtt_pkg::PRESCALE_MAX : ps;
	endfunction

	logic [7:0] pre_cnt;
	logic       pre_tick;
	logic [8:0] pre_mask;
	assign pre_mask = (9'h001 << eff_ps(prescale_select)) - 9'h001;
	assign pre_tick = src_tick && ((pre_cnt & pre_mask[7:0]) == pre_mask[7:0]);

	// Prescaler clears with the counter so a restart gets a full period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt <= 8'h00;
		end else if (soft_rst || clr_req) begin
			pre_cnt <= 8'h00;
		end else if (run && src_tick) begin
			pre_cnt <= pre_cnt + 8'h01;
		end
	end

	// ==========================================
	// Counter and overflow flag
	logic       wrap;
	logic [7:0] limit;
	assign limit = (terminal_value == 8'h00) ? 8'hff : terminal_value;
	assign wrap  = run && pre_tick && (count == limit);

	always_comb begin
		next_count = count;
		if (clr_req) begin
			next_count = mtt_pkg::RST_COUNT;
		end else if (run && pre_tick) begin
			next_count = wrap ? 8'h00 : count + 8'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= mtt_pkg::RST_COUNT;
		end else if (soft_rst) begin
			count <= mtt_pkg::RST_COUNT;
		end else begin
			count <= next_count;
		end
	end

	// Read of status while set arms the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_seen <= 1'b0;
		end else if (soft_rst || !overflow_flag) begin
			flag_seen <= 1'b0;
		end else if (rd_sc) begin
			flag_seen <= 1'b1;
		end
	end

	always_comb begin
		next_flag = overflow_flag;
		if (clr_req) begin
			next_flag = 1'b0;
		end else if (wrap) begin
			next_flag = 1'b1;
		end else if (wr_sc && flag_seen && !hwdata[mtt_pkg::SC_OVERFLOW_FLAG]) begin
			next_flag = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overflow_flag <= 1'b0;
		end else if (soft_rst) begin
			overflow_flag <= 1'b0;
		end else begin
			overflow_flag <= next_flag;
		end
	end

	// Uses the enable as it will be, so a disabling write drops the request at once
	logic next_irq_enable;
	assign next_irq_enable = wr_sc ? hwdata[mtt_pkg::SC_IRQ_ENABLE] : overflow_irq_enable;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overflow_irq <= 1'b0;
		end else begin
			overflow_irq <= next_flag && next_irq_enable && !soft_rst;
		end
	end

	// ==========================================
	// Checks
	a_halt_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		(counter_halt && !clr_req && !soft_rst) |=> count == $past(count))
		else $error("count moved while halted");
	a_stop_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
		(stop_mode && !clr_req && !soft_rst) |=> $stable(count))
		else $error("count moved in stop");
	a_debug_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
		(debug_active && !clr_req && !soft_rst) |=> $stable(count))
		else $error("count moved in debug");
	a_clear_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		clr_req |=> (count == 8'h00 && !overflow_flag))
		else $error("clear did not zero count and flag");
	a_wrap_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		(wrap && !clr_req && !soft_rst) |=> (overflow_flag && count == 8'h00))
		else $error("wrap did not set flag");
	a_irq_follow: assert property (@(posedge hclk) disable iff (!hresetn)
		overflow_irq |-> (overflow_flag && overflow_irq_enable))
		else $error("irq without flag and enable");
	a_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
		(overflow_flag && overflow_irq_enable) |-> overflow_irq)
		else $error("flag and enable without irq");
	a_flag_arm: assert property (@(posedge hclk) disable iff (!hresetn)
		($fell(overflow_flag) && !$past(soft_rst)) |-> ($past(clr_req) || $past(flag_seen)))
		else $error("flag cleared without read");
	a_free_limit: assert property (@(posedge hclk) disable iff (!hresetn)
		(terminal_value != 8'h00 && !wr_tv) |-> count <= terminal_value)
		else $error("count beyond terminal value");
	a_bus_step: assert property (@(posedge hclk) disable iff (!hresetn)
		(run && clock_source_select == 2'b00 && prescale_select == 4'h0 && !clr_req
		&& !soft_rst && count != limit) |=> count == $past(count) + 8'h01)
		else $error("divide-by-one did not step");
	a_sc_low_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(ph_valid && !ph_write && ph_addr == mtt_pkg::ADDR_STATUS_CONTROL)
		|-> (hrdata[3:0] == 4'h0 && !hrdata[mtt_pkg::SC_COUNTER_CLEAR]))
		else $error("status unused or clear bits read non-zero");
	a_ext_rise_once: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_rise |=> !ext_rise)
		else $error("pin rise pulse longer than one cycle");
	a_ext_fall_once: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_fall |=> !ext_fall)
		else $error("pin fall pulse longer than one cycle");
	a_cfg_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(!wr_cfg && !soft_rst) |=> $stable(clock_source_select))
		else $error("source select changed without a write");
	a_count_ro: assert property (@(posedge hclk) disable iff (!hresetn)
		(ph_valid && ph_write && ph_addr == mtt_pkg::ADDR_COUNT && !run && !soft_rst)
		|=> $stable(count))
		else $error("count write took effect");
	a_prescale_cap: assert property (@(posedge hclk) disable iff (!hresetn)
		pre_mask <= 9'h0ff)
		else $error("prescaler beyond divide by 256");
endmodule

// [sim/modulo_tick_timer_tb_top.sv]
`timescale 1ns/100ps
module modulo_tick_timer_tb_top;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        fixed_rate_clock = 1'b0;
	logic        ext_count_clock_in = 1'b0;
	logic        stop_mode = 1'b0;
	logic        deep_stop_wake = 1'b0;
	logic        debug_active = 1'b0;
	logic        overflow_irq;
	logic [31:0] d;
	logic [31:0] e;
	int          n_fail = 0;
	int          samples_checked = 0;
	localparam logic [3:0] SC = mtt_pkg::ADDR_STATUS_CONTROL;
	localparam logic [3:0] CF = mtt_pkg::ADDR_CLOCK_CONFIG;
	localparam logic [3:0] CN = mtt_pkg::ADDR_COUNT;
	localparam logic [3:0] TV = mtt_pkg::ADDR_TERMINAL_VALUE;

	// Single slave: its ready is the bus ready
	assign hready = hreadyout;

	mtt_timer dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.fixed_rate_clock(fixed_rate_clock), .ext_count_clock_in(ext_count_clock_in),
		.stop_mode(stop_mode), .deep_stop_wake(deep_stop_wake),
		.debug_active(debug_active), .overflow_irq(overflow_irq)
	);

	initial begin
		forever #5 hclk = ~hclk;
	end

	// ==========================================
	// Bus tasks, always entered just after a rising edge
	task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] wd,
			output logic [31:0] rd);
		htrans <= 2'h2;
		haddr  <= {28'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		// Sampled before this edge's register updates land
		rd = hrdata;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		logic [31:0] x;
		xfer(a, 1'b1, {24'h0, v}, x);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rdc(input logic [3:0] a, input logic [7:0] v);
		xfer(a, 1'b0, 32'h0, d);
		chk(d, {24'h0, v});
	endtask

	task automatic pulses(input logic on_fixed, input int n);
		for (int i = 0; i < n; i++) begin
			if (on_fixed) fixed_rate_clock <= 1'b1; else ext_count_clock_in <= 1'b1;
			repeat (4) @(posedge hclk);
			if (on_fixed) fixed_rate_clock <= 1'b0; else ext_count_clock_in <= 1'b0;
			repeat (4) @(posedge hclk);
		end
		repeat (4) @(posedge hclk);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		rdc(SC, 8'h10);
		rdc(CF, 8'h00);
		rdc(CN, 8'h00);
		rdc(TV, 8'h00);
		chk({31'h0, overflow_irq}, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		chk({31'h0, hreadyout}, 32'h1);
		wr(CN, 8'h55);
		rdc(CN, 8'h00);
		rdc(4'h1, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_modulo;
		wr(TV, 8'h03);
		wr(SC, 8'h00);
		repeat (10) @(posedge hclk);
		wr(SC, 8'h10);
		xfer(CN, 1'b0, 32'h0, d);
		chk({31'h0, d > 32'h3}, 32'h0);
		rdc(CN, d[7:0]);
		rdc(SC, 8'h90);
		wr(SC, 8'h10);
		rdc(SC, 8'h10);
		wr(SC, 8'h40);
		repeat (10) @(posedge hclk);
		chk({31'h0, overflow_irq}, 32'h1);
		wr(SC, 8'h70);
		rdc(CN, 8'h00);
		rdc(SC, 8'h50);
		chk({31'h0, overflow_irq}, 32'h0);
		wr(SC, 8'h00);
		repeat (10) @(posedge hclk);
		wr(SC, 8'h10);
		wr(TV, 8'h00);
		rdc(SC, 8'h10);
		rdc(CN, 8'h00);
		$display("test modulo done");
	endtask

	task automatic t_prescale;
		wr(SC, 8'h00);
		repeat (300) @(posedge hclk);
		wr(SC, 8'h10);
		xfer(SC, 1'b0, 32'h0, d);
		chk({31'h0, d[7]}, 32'h1);
		foreach (e[i]) if (i < 2) begin
			wr(CF, i ? 8'h0f : 8'h08);
			wr(SC, 8'h20);
			repeat (300) @(posedge hclk);
			wr(SC, 8'h10);
			rdc(CN, 8'h01);
		end
		$display("test prescale done");
	endtask

	task automatic t_sources;
		for (int s = 1; s < 4; s++) begin
			wr(CF, {2'h0, s[1:0], 4'h0});
			wr(SC, 8'h20);
			pulses(s == 1, 5);
			wr(SC, 8'h10);
			rdc(CN, 8'h05);
		end
		wr(CF, 8'h00);
		$display("test sources done");
	endtask

	task automatic t_suspend(input logic dbg);
		wr(SC, 8'h20);
		if (dbg) debug_active <= 1'b1; else stop_mode <= 1'b1;
		repeat (3) @(posedge hclk);
		xfer(CN, 1'b0, 32'h0, e);
		repeat (10) @(posedge hclk);
		rdc(CN, e[7:0]);
		debug_active <= 1'b0;
		stop_mode <= 1'b0;
		repeat (5) @(posedge hclk);
		xfer(CN, 1'b0, 32'h0, d);
		chk({31'h0, d === e}, 32'h0);
		$display("test suspend done");
	endtask

	task automatic t_deep_wake;
		wr(TV, 8'h07);
		wr(CF, 8'h13);
		deep_stop_wake <= 1'b1;
		@(posedge hclk);
		deep_stop_wake <= 1'b0;
		@(posedge hclk);
		rdc(SC, 8'h10);
		rdc(CF, 8'h00);
		rdc(TV, 8'h00);
		rdc(CN, 8'h00);
		$display("test deep wake done");
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Runs take about 1200 cycles; the margin covers a stuck handshake
	initial begin
		#200000;
		n_fail++;
		finish_test;
	end

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_modulo;
		t_prescale;
		t_sources;
		t_suspend(1'b1);
		t_suspend(1'b0);
		t_deep_wake;
		finish_test;
	end
endmodule
